/* verilog/voice_if_pkg.sv */
package voice_if_pkg;
  localparam int          FRAME_BITS      = 16;
  localparam int          OP_W            = 4;
  localparam int          ARG_W           = 12;
  localparam int          OP_MSB          = 15;
  localparam int          OP_LSB          = 12;
  localparam int          DIV_W           = 8;
  localparam int          CNT_W           = 16;
  localparam logic [3:0]  OP_NOP          = 4'h0;
  localparam logic [3:0]  OP_POWERUP      = 4'h1;
  localparam logic [3:0]  OP_SET_PLAY     = 4'h2;
  localparam logic [3:0]  OP_SET_REC      = 4'h3;
  localparam logic [3:0]  OP_PLAY         = 4'h4;
  localparam logic [3:0]  OP_REC          = 4'h5;
  localparam logic [3:0]  OP_STOP         = 4'h6;
  localparam logic [7:0]  EXT_DIV_RST     = 8'h00;
  localparam logic [11:0] ADDR_RST        = 12'h000;
  localparam logic [11:0] ADDR_LAST       = 12'hFFF;
  localparam int          CLK_HZ          = 40000000;
  localparam int          INT_SAMPLE_HZ   = 6400;
  localparam int          EXT_TIMEOUT_NS  = 10000;
  localparam int          CLK_PERIOD_NS   = 25;
  localparam int          EXT_TIMEOUT_CYC = EXT_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int          INT_DIV_CYC     = CLK_HZ / INT_SAMPLE_HZ;
  localparam int          SEG_SAMPLES     = 64;
  localparam int          NSYNC           = 6;
  localparam logic [5:0]  SYNC_RST        = 6'h02;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PLAY = 2'b01,
    ST_REC  = 2'b10
  } eng_state_t;
endpackage

/* verilog/voice_host_if.sv */
// What this block does
// [RULE1] Each serial_in bit is captured on the rising serial clock edge.
// [RULE2] serial_out changes on the falling serial clock edge, valid after it.
// [RULE3] The device joins transfers only while the host holds chip_select_n low.
// [RULE4] With chip_select_n high, serial_out floats and serial_in is ignored.
// [RULE5] segment_near_end_n goes low as the current segment nears its end.
// [RULE6] irq_out_n is open drain, pulled low on end of message or overflow.
// [RULE7] A live ext_sample_clock_in replaces the internal sampling oscillator.
// [RULE8] The reset pin clears address registers and restores power-up defaults.
// [RULE9] squelch_active_n is low while the squelch function is engaged.
// [RULE10] Squelch works with the cap pin grounded, disabled when tied high.
// [RULE11] segment_near_end_n falls at half segment, rises at segment end.
// [RULE12] Commands taken while low; later ones wait for the next segment cycle.
// [RULE13] Host issues the next segment command before segment_near_end_n rises.
// [RULE14] A power-up command with low supply also raises the interrupt.
// [RULE15] Rising chip_select_n clears the bit counter and drops partial frames.
`timescale 1ns/1ps
module voice_host_if
  import voice_if_pkg::*;
#(
  parameter int INT_DIV  = INT_DIV_CYC,
  parameter int SEG_LEN  = SEG_SAMPLES
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic sclk,
  input  wire logic chip_select_n,
  input  wire logic serial_in,
  output logic      serial_out,
  output logic      serial_out_en,
  input  wire logic reset_pin_n,
  input  wire logic ext_sample_clock_in,
  input  wire logic squelch_cap_pin,
  input  wire logic audio_quiet,
  input  wire logic low_supply,
  output logic      segment_near_end_n,
  output logic      irq_out_n,
  output logic      irq_out_en,
  output logic      busy_n,
  output logic      squelch_active_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Serial clock domain.

  logic [4:0]            bit_cnt;
  logic [4:0]            next_bit_cnt;
  logic [FRAME_BITS-1:0] shreg;
  logic [FRAME_BITS-1:0] next_shreg;
  logic [FRAME_BITS-1:0] rx_word = '0;
  logic [FRAME_BITS-1:0] next_rx_word;
  logic                  frame_tgl = 1'b0;
  logic                  next_frame_tgl;
  logic                  frame_end;

  always_comb begin
    frame_end      = (bit_cnt == 5'(FRAME_BITS - 1));
    next_shreg     = {shreg[FRAME_BITS-2:0], serial_in};
    next_bit_cnt   = frame_end ? 5'h00 : bit_cnt + 5'h01;
    next_rx_word   = frame_end ? next_shreg : rx_word;
    next_frame_tgl = frame_end ? ~frame_tgl : frame_tgl;
  end

  // Deselecting throws away any half-received frame.
  always_ff @(posedge sclk or posedge chip_select_n) begin
    if (chip_select_n) begin // [RULE4] [RULE15]
      bit_cnt <= 5'h00;
      shreg   <= '0;
    end else begin
      bit_cnt <= next_bit_cnt; // [RULE1] [RULE3]
      shreg   <= next_shreg; // [RULE1]
    end
  end

  // A word stays put for a whole frame, far longer than the crossing takes.
  always_ff @(posedge sclk) begin
    rx_word   <= next_rx_word;
    frame_tgl <= next_frame_tgl;
  end

  // Outgoing data is the stream delayed by one frame, so parts can cascade.
  always_ff @(negedge sclk or posedge chip_select_n) begin
    if (chip_select_n) begin // [RULE4]
      serial_out    <= 1'b0;
      serial_out_en <= 1'b0;
    end else begin
      serial_out    <= shreg[FRAME_BITS-1]; // [RULE2]
      serial_out_en <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  logic [NSYNC-1:0] sync_in;
  logic [NSYNC-1:0] sync_q1;
  logic [NSYNC-1:0] sync_q2;

  assign sync_in = {low_supply, audio_quiet, squelch_cap_pin,
                    ext_sample_clock_in, reset_pin_n, frame_tgl};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      // The toggle chain runs through reset, so a reset never replays the last word.
      always_ff @(posedge clk) begin
        if (sys_rst && gi != 0) begin
          sync_q1[gi] <= SYNC_RST[gi];
          sync_q2[gi] <= SYNC_RST[gi];
        end else begin
          sync_q1[gi] <= sync_in[gi];
          sync_q2[gi] <= sync_q1[gi];
        end
      end
    end
  endgenerate

  logic tgl_s;
  logic rst_pin_s;
  logic ext_s;
  logic cap_s;
  logic quiet_s;
  logic low_s;
  logic dev_clear;

  assign tgl_s     = sync_q2[0];
  assign rst_pin_s = sync_q2[1];
  assign ext_s     = sync_q2[2];
  assign cap_s     = sync_q2[3];
  assign quiet_s   = sync_q2[4];
  assign low_s     = sync_q2[5];
  assign dev_clear = sys_rst | ~rst_pin_s; // [RULE8]

  ////////////////////////////////////////////////////////////////////////////
  // Sample clock selection.

  logic             tgl_seen;
  logic             ext_d;
  logic [CNT_W-1:0] ext_live;
  logic [CNT_W-1:0] next_ext_live;
  logic [DIV_W-1:0] ext_cnt;
  logic [DIV_W-1:0] next_ext_cnt;
  logic [CNT_W-1:0] int_cnt;
  logic [CNT_W-1:0] next_int_cnt;
  logic [DIV_W-1:0] ext_div;
  logic             ext_edge;
  logic             ext_tick;
  logic             int_tick;
  logic             sample_tick;
  logic             cmd_strobe;

  always_comb begin
    cmd_strobe    = (tgl_s != tgl_seen);
    ext_edge      = ext_s & ~ext_d;
    next_ext_live = ext_edge ? CNT_W'(EXT_TIMEOUT_CYC) :
                    (ext_live != '0) ? ext_live - 1'b1 : ext_live;
    ext_tick      = ext_edge && (ext_cnt == ext_div);
    next_ext_cnt  = !ext_edge ? ext_cnt : ext_tick ? '0 : ext_cnt + 1'b1;
    int_tick      = (int_cnt == CNT_W'(INT_DIV - 1));
    next_int_cnt  = int_tick ? '0 : int_cnt + 1'b1;
    // The external source wins only while its edges keep arriving.
    sample_tick   = (ext_live != '0) ? ext_tick : int_tick; // [RULE7]
  end

  always_ff @(posedge clk) begin
    if (dev_clear) begin
      tgl_seen <= tgl_s;
      ext_d    <= 1'b0;
      ext_live <= '0;
      ext_cnt  <= '0;
      int_cnt  <= '0;
    end else begin
      tgl_seen <= tgl_s;
      ext_d    <= ext_s;
      ext_live <= next_ext_live;
      ext_cnt  <= next_ext_cnt;
      int_cnt  <= next_int_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Segment engine.

  eng_state_t       state;
  eng_state_t       next_state;
  logic [ARG_W-1:0] addr;
  logic [ARG_W-1:0] next_addr;
  logic [CNT_W-1:0] samp;
  logic [CNT_W-1:0] next_samp;
  logic             pend;
  logic             next_pend;
  logic [OP_W-1:0]  pend_op;
  logic [OP_W-1:0]  next_pend_op;
  logic [ARG_W-1:0] pend_arg;
  logic [ARG_W-1:0] next_pend_arg;
  logic [DIV_W-1:0] next_ext_div;
  logic             next_near_n;
  logic             next_irq;
  logic             next_busy_n;
  logic             next_sq_n;
  logic [OP_W-1:0]  op;
  logic [ARG_W-1:0] arg;
  logic             seg_end;

  always_comb begin
    op            = rx_word[OP_MSB:OP_LSB];
    arg           = rx_word[ARG_W-1:0];
    next_state    = state;
    next_addr     = addr;
    next_samp     = samp;
    next_pend     = pend;
    next_pend_op  = pend_op;
    next_pend_arg = pend_arg;
    next_ext_div  = ext_div;
    next_near_n   = segment_near_end_n;
    next_irq      = irq_out_en;
    seg_end       = 1'b0;
    if (cmd_strobe) begin
      next_irq = 1'b0;
      if (op == OP_POWERUP) begin
        next_ext_div = arg[DIV_W-1:0];
        next_irq     = low_s; // [RULE14]
      end else if (state == ST_IDLE) begin
        if (op == OP_SET_PLAY || op == OP_PLAY) begin
          next_state = ST_PLAY;
        end else if (op == OP_SET_REC || op == OP_REC) begin
          next_state = ST_REC;
        end
        if (op == OP_SET_PLAY || op == OP_SET_REC) begin
          next_addr = arg;
        end
        next_samp = '0;
      end else if (op != OP_NOP) begin
        // Running: the command waits for the next segment boundary.
        next_pend     = 1'b1; // [RULE12]
        next_pend_op  = op;
        next_pend_arg = arg;
      end
    end
    if (sample_tick && state != ST_IDLE) begin
      next_samp = samp + 1'b1;
      if (samp == CNT_W'(SEG_LEN / 2 - 1)) begin
        next_near_n = 1'b0; // [RULE5] [RULE11]
      end
      if (samp == CNT_W'(SEG_LEN - 1)) begin
        seg_end     = 1'b1;
        next_samp   = '0;
        next_near_n = 1'b1; // [RULE11]
        // A command landing on the boundary itself waits for the following one if the engine runs on, and is dropped if it goes idle.
        next_pend   = cmd_strobe && op != OP_NOP && op != OP_POWERUP; // [RULE12]
        if (!pend || pend_op == OP_STOP) begin
          next_state = ST_IDLE;
          next_irq   = next_irq | !pend; // [RULE6]
        end else if (pend_op == OP_SET_PLAY || pend_op == OP_SET_REC) begin
          next_addr  = pend_arg; // [RULE12] [RULE13]
          next_state = (pend_op == OP_SET_PLAY) ? ST_PLAY : ST_REC;
        end else if (addr == ADDR_LAST) begin
          next_state = ST_IDLE;
          next_irq   = 1'b1; // [RULE6]
        end else begin
          next_addr  = addr + 1'b1;
          next_state = (pend_op == OP_PLAY) ? ST_PLAY : ST_REC;
        end
      end
    end
    if (next_state == ST_IDLE) begin
      next_near_n = 1'b1;
      next_pend   = 1'b0;
    end
    next_busy_n = (next_state == ST_IDLE);
    next_sq_n   = ~(next_state == ST_PLAY && !cap_s && quiet_s); // [RULE9] [RULE10]
  end

  always_ff @(posedge clk) begin
    if (dev_clear) begin // [RULE8]
      state              <= ST_IDLE;
      addr               <= ADDR_RST;
      samp               <= '0;
      pend               <= 1'b0;
      pend_op            <= OP_NOP;
      pend_arg           <= ADDR_RST;
      ext_div            <= EXT_DIV_RST;
      segment_near_end_n <= 1'b1;
      irq_out_en         <= 1'b0;
      irq_out_n          <= 1'b0;
      busy_n             <= 1'b1;
      squelch_active_n   <= 1'b1;
    end else begin
      state              <= next_state;
      addr               <= next_addr;
      samp               <= next_samp;
      pend               <= next_pend;
      pend_op            <= next_pend_op;
      pend_arg           <= next_pend_arg;
      ext_div            <= next_ext_div;
      segment_near_end_n <= next_near_n;
      irq_out_en         <= next_irq; // [RULE6]
      irq_out_n          <= 1'b0; // [RULE6]
      busy_n             <= next_busy_n;
      squelch_active_n   <= next_sq_n;
    end
  end

endmodule

/* tb/voice_host_if_chk.sv */
`timescale 1ns/1ps
module voice_host_if_chk (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic chip_select_n,
  input wire logic reset_pin_n,
  input wire logic squelch_cap_pin,
  input wire logic serial_out_en,
  input wire logic segment_near_end_n,
  input wire logic irq_out_n,
  input wire logic irq_out_en,
  input wire logic busy_n,
  input wire logic squelch_active_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_float; chip_select_n |-> !serial_out_en; endproperty
  a_float: assert property (p_float) else $error("driving while deselected");
  property p_od; !irq_out_n; endproperty
  a_od: assert property (p_od) else $error("irq data not low");
  property p_irq; $rose(irq_out_en) |-> busy_n; endproperty
  a_irq: assert property (p_irq) else $error("irq while running");
  property p_fall; $fell(segment_near_end_n) |-> !busy_n; endproperty
  a_fall: assert property (p_fall) else $error("near end while idle");
  property p_end; $rose(busy_n) |-> segment_near_end_n; endproperty
  a_end: assert property (p_end) else $error("near end low at stop");
  property p_rest; busy_n [*2] |-> segment_near_end_n; endproperty
  a_rest: assert property (p_rest) else $error("near end not resting");
  property p_cap; squelch_cap_pin [*4] |-> squelch_active_n; endproperty
  a_cap: assert property (p_cap) else $error("squelch while disabled");
  property p_sq; busy_n [*4] |-> squelch_active_n; endproperty
  a_sq: assert property (p_sq) else $error("squelch while idle");
  property p_rpin; !reset_pin_n [*4] |=> busy_n && segment_near_end_n && !irq_out_en; endproperty
  a_rpin: assert property (p_rpin) else $error("reset pin ignored");
  c_fall: cover property ($fell(segment_near_end_n));
  c_irq: cover property ($rose(irq_out_en));
  c_sq: cover property (!squelch_active_n);
endmodule
bind voice_host_if voice_host_if_chk voice_host_if_chk_i (.clk(clk), .sys_rst(sys_rst),
  .chip_select_n(chip_select_n), .reset_pin_n(reset_pin_n), .squelch_cap_pin(squelch_cap_pin),
  .serial_out_en(serial_out_en), .segment_near_end_n(segment_near_end_n),
  .irq_out_n(irq_out_n), .irq_out_en(irq_out_en), .busy_n(busy_n),
  .squelch_active_n(squelch_active_n));

/* tb/host_spi_model.sv */
`timescale 1ns/1ps
module host_spi_model (
  output logic      sclk,
  output logic      chip_select_n,
  output logic      serial_in,
  input  wire logic serial_out
);
  initial begin
    sclk = 1'b0;
    chip_select_n = 1'b1;
    serial_in = 1'b0;
  end
  // The serial clock stands low outside frames; data changes only while it is low.
  task automatic frame(input logic [31:0] tx, input int n, output logic [31:0] rx);
    rx = '0;
    chip_select_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      serial_in = tx[31-i];
      #62.5;
      rx = {rx[30:0], serial_out};
      sclk = 1'b1;
      #62.5;
      sclk = 1'b0;
    end
    #62.5;
    chip_select_n = 1'b1;
    serial_in = ~serial_in;
  endtask
endmodule

/* tb/test_voice_host_if.sv */
`timescale 1ns/1ps
module test_voice_host_if;
  import voice_if_pkg::*;
  logic clk, sys_rst, sclk, chip_select_n, serial_in, serial_out, serial_out_en, reset_pin_n;
  logic ext_sample_clock_in, squelch_cap_pin, audio_quiet, low_supply, segment_near_end_n;
  logic irq_out_n, irq_out_en, busy_n, squelch_active_n, ext_run;
  logic [31:0] rx;
  int err_total, checks, n;
  voice_host_if #(.INT_DIV(8), .SEG_LEN(32)) voice_host_if_i (.clk(clk), .sys_rst(sys_rst),
    .sclk(sclk), .chip_select_n(chip_select_n), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_en(serial_out_en), .reset_pin_n(reset_pin_n),
    .ext_sample_clock_in(ext_sample_clock_in), .squelch_cap_pin(squelch_cap_pin),
    .audio_quiet(audio_quiet), .low_supply(low_supply),
    .segment_near_end_n(segment_near_end_n), .irq_out_n(irq_out_n),
    .irq_out_en(irq_out_en), .busy_n(busy_n), .squelch_active_n(squelch_active_n));
  host_spi_model host_spi_model_i (.sclk(sclk), .chip_select_n(chip_select_n),
    .serial_in(serial_in), .serial_out(serial_out));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) ext_sample_clock_in <= ext_run ? ~ext_sample_clock_in : 1'b0;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Bounded wait; a miss is not flagged here, and no later comparison catches one in t_ext, t_rst or the segment-end wait of t_play.
  task automatic wait_lvl(input bit near, input logic v, input int lim);
    for (int i = 0; i < lim && (near ? segment_near_end_n : busy_n) !== v; i++) begin
      @(posedge clk);
    end
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic t_echo;
    host_spi_model_i.frame({OP_NOP, 12'hA5C, 16'h0000}, 32, rx);
    @(posedge clk);
    chk(rx[15:0], 16'h0A5C);
    chk(serial_out_en, 1'b0);
    $display("echo test done");
  endtask
  task automatic t_partial;
    host_spi_model_i.frame({OP_SET_PLAY, 12'h010, 16'h0}, 8, rx);
    repeat (4) @(posedge clk);
    host_spi_model_i.frame({OP_NOP, 12'h000, 16'h0}, 16, rx);
    chk(rx[15:0], 16'h0000);
    repeat (20) @(posedge clk);
    chk(busy_n, 1'b1);
    $display("partial test done");
  endtask
  task automatic t_play;
    audio_quiet <= 1'b1;
    host_spi_model_i.frame({OP_SET_PLAY, 12'h020, 16'h0}, 16, rx);
    wait_lvl(1'b0, 1'b0, 20);
    chk(busy_n, 1'b0);
    repeat (8) @(posedge clk);
    chk(squelch_active_n, 1'b0);
    wait_lvl(1'b1, 1'b0, 300);
    chk(segment_near_end_n, 1'b0);
    host_spi_model_i.frame({OP_PLAY, 12'h000, 16'h0}, 16, rx);
    wait_lvl(1'b1, 1'b1, 300);
    chk(busy_n, 1'b0);
    squelch_cap_pin <= 1'b1;
    repeat (6) @(posedge clk);
    chk(squelch_active_n, 1'b1);
    wait_lvl(1'b0, 1'b1, 600);
    @(posedge clk);
    chk(segment_near_end_n, 1'b1);
    chk(irq_out_en, 1'b1);
    audio_quiet <= 1'b0;
    squelch_cap_pin <= 1'b0;
    $display("play test done");
  endtask
  task automatic t_powerup;
    host_spi_model_i.frame({OP_NOP, 12'h000, 16'h0}, 16, rx);
    repeat (10) @(posedge clk);
    chk(irq_out_en, 1'b0);
    low_supply <= 1'b1;
    host_spi_model_i.frame({OP_POWERUP, 12'h000, 16'h0}, 16, rx);
    repeat (10) @(posedge clk);
    chk(irq_out_en, 1'b1);
    low_supply <= 1'b0;
    $display("powerup test done");
  endtask
  // A tick every two clocks gives a 64-clock segment against 256 from the oscillator.
  task automatic t_ext;
    ext_run <= 1'b1;
    repeat (20) @(posedge clk);
    host_spi_model_i.frame({OP_SET_PLAY, 12'h040, 16'h0}, 16, rx);
    wait_lvl(1'b0, 1'b0, 20);
    for (n = 0; n < 600 && busy_n !== 1'b1; n++) @(posedge clk);
    chk(n < 100, 1'b1);
    ext_run <= 1'b0;
    $display("ext clock test done");
  endtask
  task automatic t_rst;
    host_spi_model_i.frame({OP_SET_PLAY, 12'h080, 16'h0}, 16, rx);
    wait_lvl(1'b0, 1'b0, 20);
    reset_pin_n <= 1'b0;
    repeat (6) @(posedge clk);
    chk({busy_n, segment_near_end_n, irq_out_en}, 3'b110);
    reset_pin_n <= 1'b1;
    repeat (4) @(posedge clk);
    $display("reset pin test done");
  endtask
  initial begin
    {err_total, checks} = 0;
    {sys_rst, reset_pin_n} = 2'b11;
    {squelch_cap_pin, audio_quiet, low_supply, ext_run} = '0;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_echo();
    t_partial();
    t_play();
    t_powerup();
    t_ext();
    t_rst();
    wrap_up();
  end
  initial begin
    #200000;
    err_total++;
    wrap_up();
  end
endmodule
